// *** pkg/rsi_pkg.sv ***
// Constants for the rectifier status indicator
package rsi_pkg;
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned PULSE_MS     = 1;
  localparam int unsigned PULSE_CYC    = CLK_HZ / 1000 * PULSE_MS;
  localparam int unsigned BLINK_MS     = 250;
  localparam int unsigned BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned CNT_W        = 26;
  localparam logic [1:0]  MODE_ANALOG  = 2'h0;
  localparam logic [1:0]  MODE_I2C     = 2'h1;
  localparam logic [1:0]  MODE_RS485   = 2'h2;
  localparam logic        RST_TOGGLE   = 1'h0;
  localparam logic [2:0]  RST_SYNC     = 3'h7;
  localparam logic        RST_ON       = 1'h0;
  localparam logic        RST_LED      = 1'h0;
  localparam logic        RST_OE       = 1'h0;
  localparam logic        RST_GOOD_OE  = 1'h1;
  localparam logic [CNT_W-1:0] RST_CNT = 26'h0000000;
endpackage : rsi_pkg

// *** core/rsi_toggler.sv ***
// Free running half-period toggler for blink and pulse timing
`timescale 1ns/1ps
module rsi_toggler #(
  parameter logic [25:0] HALF_CYC = 26'h0000001
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Square wave
  output logic      wave
);
  logic [25:0] cnt;
  logic [25:0] next_cnt;
  logic        next_wave;

  always_comb begin
    next_cnt  = cnt + 26'h0000001;
    next_wave = wave;
    if (cnt >= HALF_CYC - 26'h0000001) begin
      next_cnt  = rsi_pkg::RST_CNT;
      next_wave = ~wave;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt  <= rsi_pkg::RST_CNT;
      wave <= rsi_pkg::RST_TOGGLE;
    end else begin
      cnt  <= next_cnt;
      wave <= next_wave;
    end
  end
endmodule : rsi_toggler

// *** core/rsi_top.sv ***
// Status LEDs, open-drain status pins and output enable qualification
`timescale 1ns/1ps
module rsi_top (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Mode and switches
  input  wire logic [1:0] comm_mode,
  input  wire logic       dip_onoff_on,
  input  wire logic       enable_pin_n,
  input  wire logic       enable_rs485,
  // Internal conditions
  input  wire logic       input_present,
  input  wire logic       input_in_limits,
  input  wire logic       overload,
  input  wire logic       thermal_alarm,
  input  wire logic       thermal_shutdown,
  input  wire logic       hard_fault,
  input  wire logic       soft_fault,
  input  wire logic       standby_cmd,
  input  wire logic       service_request,
  input  wire logic       comm_lost,
  // Main output control
  output logic            main_output_on,
  // Front panel LEDs
  output logic            led_input,
  output logic            led_output,
  output logic            led_service,
  output logic            led_fault,
  // Open-drain status pins, oe high pulls low
  output logic            fault_n_oe,
  output logic            overtemp_warning_n_oe,
  output logic            power_good_out_oe,
  // Pin input levels, unused by logic
  input  wire logic       fault_n_in,
  input  wire logic       overtemp_warning_n_in,
  input  wire logic       power_good_out_in,
  // Driven levels, applied while oe is high
  output logic            fault_n_out,
  output logic            overtemp_warning_n_out,
  output logic            power_good_out_out
);
  // Pin and switch inputs pass two flops; status conditions assumed synchronous
  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] next_meta;
  logic [2:0] next_sync;
  logic       blink;
  logic       good_wave;
  logic       en_pin_sync;
  logic       dip_sync;
  logic       rs_en_sync;

  always_comb begin
    next_meta = {enable_rs485, dip_onoff_on, enable_pin_n};
    next_sync = meta;
  end

  // Sync resets to the pulled-up pin levels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= rsi_pkg::RST_SYNC;
      sync <= rsi_pkg::RST_SYNC;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
    end
  end

  assign en_pin_sync = sync[0];
  assign dip_sync    = sync[1];
  assign rs_en_sync  = sync[2];

  // Both timers free-run, so every blinking LED stays in step
  rsi_toggler #(.HALF_CYC(26'(rsi_pkg::BLINK_CYC))) u_blink (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wave    (blink)
  );

  rsi_toggler #(.HALF_CYC(26'(rsi_pkg::PULSE_CYC))) u_good_pulse (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wave    (good_wave)
  );

  // Mode and enable decode
  logic is_rs485;
  logic is_i2c;
  logic enable_req;
  logic fault_req;
  logic warning_req;

  // Next values of the registered outputs
  logic next_main_output_on;
  logic next_led_input;
  logic next_led_output;
  logic next_led_service;
  logic next_led_fault;
  logic next_fault_oe;
  logic next_warning_oe;
  logic next_power_good_oe;

  // Mode code 3 is unused and behaves as analog
  always_comb begin
    is_rs485 = (comm_mode == rsi_pkg::MODE_RS485);
    is_i2c   = (comm_mode == rsi_pkg::MODE_I2C);
  end

  // Enable pin is dead while the DIP switch is on
  always_comb begin
    if (is_rs485) begin
      enable_req = rs_en_sync;
    end else if (dip_sync) begin
      enable_req = 1'h1;
    end else begin
      enable_req = ~en_pin_sync;
    end
  end

  // One map drives every LED and status pin
  always_comb begin
    // Standby wins over every enable source
    next_main_output_on = enable_req && !standby_cmd;
    // Defaults: normal operation
    next_led_input     = input_present;
    next_led_output    = 1'h1;
    next_led_service   = 1'h0;
    next_led_fault     = 1'h0;
    fault_req          = 1'h0;
    warning_req        = 1'h0;
    next_power_good_oe = 1'h0;
    // Priority: shutdown outranks warnings, overlays last
    if (!input_present) begin
      next_led_output    = 1'h0;
      next_power_good_oe = 1'h1;
    end else if (thermal_shutdown) begin
      next_led_output    = 1'h0;
      next_led_service   = 1'h1;
      next_led_fault     = 1'h1;
      fault_req          = 1'h1;
      warning_req        = 1'h1;
      next_power_good_oe = 1'h1;
    end else if (hard_fault) begin
      next_led_output    = 1'h0;
      next_led_fault     = 1'h1;
      fault_req          = 1'h1;
      next_power_good_oe = 1'h1;
    end else if (!input_in_limits) begin
      next_led_input     = is_i2c ? blink : 1'h1;
      next_led_output    = 1'h0;
      next_power_good_oe = 1'h1;
    end else if (standby_cmd || !enable_req) begin
      next_led_output    = 1'h0;
      next_power_good_oe = 1'h1;
    end else begin
      // Overlays stack, so an overload never hides a fault
      if (overload) begin
        next_led_output    = blink;
        next_power_good_oe = good_wave;
      end
      if (thermal_alarm) begin
        next_led_service = 1'h1;
        warning_req      = 1'h1;
      end else if (service_request && is_i2c) begin
        next_led_service = blink;
      end
      if (soft_fault) begin
        next_led_fault = 1'h1;
        fault_req      = 1'h1;
      end else if (is_rs485 && comm_lost) begin
        next_led_fault = blink;
      end
    end
    // RS485 mode leaves fault and warning pins released
    next_fault_oe   = fault_req && !is_rs485;
    next_warning_oe = warning_req && !is_rs485;
  end

  // Power good pulled low in reset, so a unit in reset never reads as good
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      main_output_on        <= rsi_pkg::RST_ON;
      led_input             <= rsi_pkg::RST_LED;
      led_output            <= rsi_pkg::RST_LED;
      led_service           <= rsi_pkg::RST_LED;
      led_fault             <= rsi_pkg::RST_LED;
      fault_n_oe            <= rsi_pkg::RST_OE;
      overtemp_warning_n_oe <= rsi_pkg::RST_OE;
      power_good_out_oe     <= rsi_pkg::RST_GOOD_OE;
    end else begin
      main_output_on        <= next_main_output_on;
      led_input             <= next_led_input;
      led_output            <= next_led_output;
      led_service           <= next_led_service;
      led_fault             <= next_led_fault;
      fault_n_oe            <= next_fault_oe;
      overtemp_warning_n_oe <= next_warning_oe;
      power_good_out_oe     <= next_power_good_oe;
    end
  end

  // Open-drain pins only ever pull low
  assign fault_n_out            = 1'h0;
  assign overtemp_warning_n_out = 1'h0;
  assign power_good_out_out     = 1'h0;
endmodule : rsi_top

// *** dv/rsi_top_assertions.sv ***
// Checker for the status LED and pin map
`timescale 1ns/1ps
module rsi_top_assertions (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Conditions and switches
  input wire logic       input_present,
  input wire logic       input_in_limits,
  input wire logic       overload,
  input wire logic       thermal_alarm,
  input wire logic       thermal_shutdown,
  input wire logic       hard_fault,
  input wire logic       soft_fault,
  input wire logic       standby_cmd,
  input wire logic       dip_onoff_on,
  input wire logic       enable_pin_n,
  input wire logic [1:0] comm_mode,
  // Outputs
  input wire logic       main_output_on,
  input wire logic       led_output,
  input wire logic       led_service,
  input wire logic       led_fault,
  input wire logic       fault_n_oe,
  input wire logic       overtemp_warning_n_oe,
  input wire logic       power_good_out_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic run = input_present && input_in_limits && !thermal_shutdown && !hard_fault && !standby_cmd;
  wire logic odm = comm_mode != 2'h2;
  // Four samples cover the two-flop sync plus the output register
  sequence s_en_on;
    (odm && !standby_cmd && (dip_onoff_on || !enable_pin_n))[*4];
  endsequence
  a_shut_map: assert property (input_present && thermal_shutdown |=>
    led_fault && led_service && !led_output && power_good_out_oe) else $error("shutdown map");
  a_limits_map: assert property (input_present && !input_in_limits && !thermal_shutdown && !hard_fault |=>
    !led_output && !led_fault && power_good_out_oe) else $error("limits map");
  // Output going off next cycle is the disabled state with enable_req low, not a miss
  a_alarm_map: assert property (run && odm && thermal_alarm && !overload && !soft_fault |=>
    !main_output_on || (led_service && overtemp_warning_n_oe && !led_fault && !power_good_out_oe))
    else $error("alarm");
  a_soft_map: assert property (run && odm && soft_fault && !overload |=>
    !main_output_on || (led_fault && fault_n_oe && led_output && !power_good_out_oe)) else $error("soft fault");
  a_standby_map: assert property (input_present && input_in_limits && !thermal_shutdown && !hard_fault &&
    standby_cmd |=> !led_output && power_good_out_oe && !main_output_on) else $error("standby");
  a_fault_rel: assert property (!thermal_shutdown && !hard_fault && !soft_fault |=> !fault_n_oe)
    else $error("fault pin");
  a_warn_rel: assert property (!thermal_alarm && !thermal_shutdown |=> !overtemp_warning_n_oe)
    else $error("warn pin");
  a_en_on: assert property (s_en_on |-> main_output_on) else $error("enable on");
  a_en_off: assert property ((odm && !dip_onoff_on && enable_pin_n)[*4] |-> !main_output_on)
    else $error("enable off");
endmodule : rsi_top_assertions

bind rsi_top rsi_top_assertions i_chk (.*);

// *** dv/rsi_ctrl_model.sv ***
// System controller view of the open-drain status pins
`timescale 1ns/1ps
module rsi_ctrl_model (
  // Pin drives from the block
  input  wire logic fe,
  input  wire logic fo,
  input  wire logic we,
  input  wire logic wo,
  input  wire logic pe,
  input  wire logic po,
  // Pulled-up pin levels
  output logic      fp,
  output logic      wp,
  output logic      pp
);
  // Released pins float to the pull-up, never the last value
  assign fp = fe ? fo : 1'b1;
  assign wp = we ? wo : 1'b1;
  assign pp = pe ? po : 1'b1;
endmodule : rsi_ctrl_model

// *** dv/tb_rsi_top.sv ***
// Bench for the status indicator
`timescale 1ns/1ps
module tb_rsi_top;
  logic        clk_sys = 1'h0, rst = 1'h1, mo, li, lo, ls, lf, fe, we, pe, fo, wo, po, fp, wp, pp;
  logic [14:0] c = 15'h0000;
  int          failures = 0, num_checks = 0;
  localparam logic [14:0] OK = 15'h3B00;
  wire logic [7:0] o = {mo, li, lo, ls, lf, fp, wp, pp};
  always #2.5 clk_sys = ~clk_sys;
  rsi_top i_dut (.clk_sys(clk_sys), .rst(rst), .comm_mode(c[14:13]), .dip_onoff_on(c[12]), .enable_pin_n(c[11]),
    .enable_rs485(c[10]), .input_present(c[9]), .input_in_limits(c[8]), .overload(c[7]), .thermal_alarm(c[6]),
    .thermal_shutdown(c[5]), .hard_fault(c[4]), .soft_fault(c[3]), .standby_cmd(c[2]), .service_request(c[1]),
    .comm_lost(c[0]), .main_output_on(mo), .led_input(li), .led_output(lo), .led_service(ls), .led_fault(lf),
    .fault_n_oe(fe), .overtemp_warning_n_oe(we), .power_good_out_oe(pe), .fault_n_in(fp),
    .overtemp_warning_n_in(wp), .power_good_out_in(pp), .fault_n_out(fo), .overtemp_warning_n_out(wo),
    .power_good_out_out(po));
  rsi_ctrl_model i_ctl (.*);
  task chk(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Blinking bits are masked; their periods outlast the run
  task set(input logic [14:0] v);
    @(posedge clk_sys) c <= v;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask : set
  task t_run;
    set(OK);
    chk("ok", o, 8'hE7);
    set(OK | 15'h0080);
    chk("overload", o & 8'hDE, 8'hC6);
    set(OK | 15'h0002);
    chk("service", o & 8'hEF, 8'hE7);
    set(OK | 15'h0004);
    chk("standby", o, 8'h46);
  endtask : t_run
  task t_therm;
    set(OK | 15'h0040);
    chk("alarm", o, 8'hF5);
    set(OK | 15'h0020);
    chk("shutdown", o & 8'h7F, 8'h58);
  endtask : t_therm
  task t_faults;
    set(15'h3A00);
    chk("limits", o & 8'h3F, 8'h06);
    set(OK | 15'h0010);
    chk("hard", o & 8'h7F, 8'h4A);
    set(OK | 15'h0008);
    chk("soft", o, 8'hEB);
  endtask : t_faults
  task t_rs485;
    set(15'h5F01);
    chk("comm lost", o & 8'hF7, 8'hE7);
    set(15'h5B00);
    chk("interlock", o, 8'h46);
  endtask : t_rs485
  task t_enable;
    set(15'h2300);
    chk("en i2c", o, 8'hE7);
    set(15'h2B00);
    chk("en high", o, 8'h46);
    set(15'h0300);
    chk("en analog", o, 8'hE7);
  endtask : t_enable
  // Mid-run reset: outputs take their reset levels at once
  task t_reset;
    @(posedge clk_sys) rst <= 1'h1;
    @(posedge clk_sys);
    #1;
    chk("in reset", o, 8'h06);
    @(posedge clk_sys) rst <= 1'h0;
    set(OK);
    chk("after reset", o, 8'hE7);
  endtask : t_reset
  task conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #10000;
    failures++;
    conclude;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    t_run;
    t_therm;
    t_faults;
    t_rs485;
    t_enable;
    t_reset;
    conclude;
  end
endmodule : tb_rsi_top
